// ==== design/lasm_defs.svh ====
`ifndef LASM_DEFS_SVH
`define LASM_DEFS_SVH
// ****************************************************************
// Register offsets
// ****************************************************************
`define LASM_ADDR_W 12
`define LASM_OFS_ALARM 12'h2C0
`define LASM_OFS_STATUS 12'h2C1
`define LASM_OFS_MASK 12'h2C2
`define LASM_OFS_LANE 12'h2C4
// ****************************************************************
// Field positions
// ****************************************************************
`define LASM_BIT_CLK 0
`define LASM_BIT_RSV1 1
`define LASM_BIT_REALIGN 2
`define LASM_BIT_LINK 3
`define LASM_BIT_PLL 4
`define LASM_BIT_FIFO 5
// ****************************************************************
// Reset values and status write mask
// ****************************************************************
`define LASM_RST_STATUS 8'h3F
`define LASM_RST_MASK 8'h3F
`define LASM_RST_LANE 8'hFF
`define LASM_STATUS_WMASK 8'h3F
`endif

// ==== design/lasm_pkg.sv ====
package lasm_pkg;
    typedef enum logic [1:0] {
        LASM_ENC_8B10B = 2'b00,
        LASM_ENC_64B66B = 2'b01
    } lasm_enc_e;

    typedef struct packed {
        logic pll_locked;
        logic link_enable;
        logic data_transfer_state;
        logic link_realign;
        logic clock_realign;
        logic divider_mismatch;
    } lasm_evt_s;

    typedef struct packed {
        logic [7:0] alarm_status_flags_reg;
        logic [7:0] alarm_mask_reg;
        logic [7:0] lane_fifo_alarm_flags_reg;
        logic [7:0] rdata_reg;
        logic link_en_d_reg;
    } lasm_state_s;
endpackage

// ==== design/lasm_alarm.sv ====
`timescale 1ns/1ps
`include "lasm_defs.svh"
// Notes on behaviour
// - PLL unlock sets status bit 4
// - 8B/10B: enabled link not in data sets bit 3
// - 64B/66B: startup or realignment sets bit 3
// - SYSREF clock realignment sets bit 2
// - AB/CD divider mismatch sets bit 0
// - Status flags sticky, write one clears
// - Reset sets all status flags
// - Mask bit one removes flag from aggregate
// - Per-lane FIFO vector set on overflow/underflow
// - Lane bit write-one clears, sets again if persisting
// - Clearing FIFO flag clears whole lane vector
// - Mask resets 0x3F, lane vector 0xFF
// - Aggregate alarm bit reads unmasked set flags
// - Any active lane FIFO error sets bit 5
// - Aggregate routable onto calibration status pin
module lasm_alarm #(
    parameter int LANES = 8
) (
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    input wire logic CLK_EN_I,
    input wire logic SOFT_RST_I,
    input wire logic [`LASM_ADDR_W-1:0] REG_ADDR_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    input wire logic [7:0] REG_WDATA_I,
    output logic [7:0] REG_RDATA_O,
    input wire lasm_pkg::lasm_enc_e ENC_MODE_I,
    input wire lasm_pkg::lasm_evt_s EVT_I,
    input wire logic [LANES-1:0] LANE_ACTIVE_I,
    input wire logic [LANES-1:0] LANE_FIFO_ERR_I,
    input wire logic CAL_STATUS_SEL_I,
    input wire logic CAL_DONE_I,
    output logic ALARM_O,
    output logic CAL_STATUS_PIN_O
);
    // ****************************************************************
    // Parameter check
    // ****************************************************************
    // The lane flag register is one byte wide
    if (LANES != 8) begin : g_lanes_check
        $error("LANES must be 8 to fit the lane flag register");
    end

    // ****************************************************************
    // State
    // ****************************************************************
    lasm_pkg::lasm_state_s st_reg;
    lasm_pkg::lasm_state_s st_next;
    logic [7:0] status_set;
    logic [7:0] lane_set;
    logic [7:0] status_clr;
    logic [7:0] lane_clr;
    logic wr_status;
    logic wr_lane;
    logic link_cond;
    logic alarm;

    // ****************************************************************
    // Set conditions
    // ****************************************************************
    // 8B/10B watches the link state; 64B/66B has no data state to watch
    always_comb begin
        if (ENC_MODE_I == lasm_pkg::LASM_ENC_8B10B) begin
            link_cond = EVT_I.link_enable && !EVT_I.data_transfer_state;
        end else begin
            // Startup is the rising edge of the enable
            link_cond = (EVT_I.link_enable && !st_reg.link_en_d_reg)
                || EVT_I.link_realign;
        end
    end

    always_comb begin
        status_set = 8'h00;
        status_set[`LASM_BIT_PLL] = !EVT_I.pll_locked;
        status_set[`LASM_BIT_LINK] = link_cond;
        status_set[`LASM_BIT_REALIGN] = EVT_I.clock_realign;
        status_set[`LASM_BIT_CLK] = EVT_I.divider_mismatch;
        status_set[`LASM_BIT_FIFO] = |(LANE_FIFO_ERR_I & LANE_ACTIVE_I);
    end

    generate
        for (genvar i = 0; i < LANES; i++) begin : g_lane
            assign lane_set[i] = LANE_FIFO_ERR_I[i];
            a_lane_bit_set: assert property (
                @(posedge REF_CLK_I) disable iff (!NRST_I)
                (CLK_EN_I && LANE_FIFO_ERR_I[i]) |=> st_reg.lane_fifo_alarm_flags_reg[i])
                else $error("lane bit not set");
        end
    endgenerate

    // ****************************************************************
    // Register access
    // ****************************************************************
    assign wr_status = REG_WR_I && (REG_ADDR_I == `LASM_OFS_STATUS);
    assign wr_lane = REG_WR_I && (REG_ADDR_I == `LASM_OFS_LANE);
    assign status_clr = wr_status ? (REG_WDATA_I & `LASM_STATUS_WMASK) : 8'h00;
    always_comb begin
        lane_clr = wr_lane ? REG_WDATA_I : 8'h00;
        if (wr_status && REG_WDATA_I[`LASM_BIT_FIFO]) begin
            lane_clr = 8'hFF;
        end
    end

    assign alarm = |(st_reg.alarm_status_flags_reg & ~st_reg.alarm_mask_reg
                     & `LASM_STATUS_WMASK);

    always_comb begin
        st_next = st_reg;
        // Enable history for the 64B/66B startup edge
        st_next.link_en_d_reg = EVT_I.link_enable;
        if (SOFT_RST_I) begin
            st_next.alarm_status_flags_reg = `LASM_RST_STATUS;
            st_next.alarm_mask_reg = `LASM_RST_MASK;
            st_next.lane_fifo_alarm_flags_reg = `LASM_RST_LANE;
        end else begin
            // Set has priority over a same-cycle clear
            st_next.alarm_status_flags_reg = ((st_reg.alarm_status_flags_reg & ~status_clr)
                | status_set) & `LASM_STATUS_WMASK;
            st_next.lane_fifo_alarm_flags_reg = (st_reg.lane_fifo_alarm_flags_reg & ~lane_clr)
                | lane_set;
            if (REG_WR_I && (REG_ADDR_I == `LASM_OFS_MASK)) begin
                st_next.alarm_mask_reg = REG_WDATA_I;
            end
        end
        if (REG_RD_I) begin
            case (REG_ADDR_I)
                `LASM_OFS_ALARM: st_next.rdata_reg = {7'h00, alarm};
                `LASM_OFS_STATUS: st_next.rdata_reg = st_reg.alarm_status_flags_reg;
                `LASM_OFS_MASK: st_next.rdata_reg = st_reg.alarm_mask_reg;
                `LASM_OFS_LANE: st_next.rdata_reg = st_reg.lane_fifo_alarm_flags_reg;
                default: st_next.rdata_reg = 8'h00;
            endcase
        end
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            st_reg.alarm_status_flags_reg <= `LASM_RST_STATUS;
            st_reg.alarm_mask_reg <= `LASM_RST_MASK;
            st_reg.lane_fifo_alarm_flags_reg <= `LASM_RST_LANE;
            st_reg.rdata_reg <= 8'h00;
            st_reg.link_en_d_reg <= 1'h0;
        end else if (CLK_EN_I) begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign REG_RDATA_O = st_reg.rdata_reg;
    assign ALARM_O = alarm;
    assign CAL_STATUS_PIN_O = CAL_STATUS_SEL_I ? alarm : CAL_DONE_I;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_pll_sets: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && !EVT_I.pll_locked) |=> st_reg.alarm_status_flags_reg[4])
        else $error("pll flag not set");
    a_realign_sets: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && EVT_I.clock_realign) |=> st_reg.alarm_status_flags_reg[2])
        else $error("realign flag not set");
    a_clk_sets: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && EVT_I.divider_mismatch) |=> st_reg.alarm_status_flags_reg[0])
        else $error("clock flag not set");
    a_link_8b: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && ENC_MODE_I == lasm_pkg::LASM_ENC_8B10B && EVT_I.link_enable
         && !EVT_I.data_transfer_state) |=> st_reg.alarm_status_flags_reg[3])
        else $error("link flag not set in 8b10b");
    a_status_clear: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && !SOFT_RST_I && wr_status && REG_WDATA_I[2] && !EVT_I.clock_realign)
        |=> !st_reg.alarm_status_flags_reg[2])
        else $error("status clear failed");
    a_lane_set: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && LANE_FIFO_ERR_I[0]) |=> st_reg.lane_fifo_alarm_flags_reg[0])
        else $error("lane flag not set");
    a_fifo_clr_all: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && !SOFT_RST_I && wr_status && REG_WDATA_I[5] && LANE_FIFO_ERR_I == '0)
        |=> st_reg.lane_fifo_alarm_flags_reg == 8'h00)
        else $error("lane vector not cleared");
    a_fifo_sets: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && |(LANE_FIFO_ERR_I & LANE_ACTIVE_I)) |=> st_reg.alarm_status_flags_reg[5])
        else $error("fifo flag not set");
    a_aggregate: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (|(st_reg.alarm_status_flags_reg[5:2] & ~st_reg.alarm_mask_reg[5:2])
         || (st_reg.alarm_status_flags_reg[0] && !st_reg.alarm_mask_reg[0])) |-> ALARM_O)
        else $error("aggregate wrong");
    a_soft_reset: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && SOFT_RST_I) |=> (st_reg.alarm_status_flags_reg == 8'h3F
         && st_reg.alarm_mask_reg == 8'h3F && st_reg.lane_fifo_alarm_flags_reg == 8'hFF))
        else $error("soft reset values wrong");

    // ****************************************************************
    // Link flag checks
    // ****************************************************************
    a_link_startup: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && ENC_MODE_I == lasm_pkg::LASM_ENC_64B66B && EVT_I.link_enable
         && !st_reg.link_en_d_reg) |=> st_reg.alarm_status_flags_reg[3])
        else $error("link flag not set at startup");
    a_link_realign: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && ENC_MODE_I == lasm_pkg::LASM_ENC_64B66B && EVT_I.link_realign)
        |=> st_reg.alarm_status_flags_reg[3])
        else $error("link flag not set on realignment");
    // A clear must stick when no link condition holds
    a_link_clr_8b: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && !SOFT_RST_I && ENC_MODE_I == lasm_pkg::LASM_ENC_8B10B && wr_status
         && REG_WDATA_I[3] && (!EVT_I.link_enable || EVT_I.data_transfer_state))
        |=> !st_reg.alarm_status_flags_reg[3])
        else $error("link flag stuck in 8b10b");
    a_link_clr_64b: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && !SOFT_RST_I && ENC_MODE_I == lasm_pkg::LASM_ENC_64B66B && wr_status
         && REG_WDATA_I[3] && !EVT_I.link_realign
         && !(EVT_I.link_enable && !st_reg.link_en_d_reg))
        |=> !st_reg.alarm_status_flags_reg[3])
        else $error("link flag stuck in 64b66b");

    // ****************************************************************
    // Clear, sticky and priority checks
    // ****************************************************************
    a_pll_clear: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && !SOFT_RST_I && wr_status && REG_WDATA_I[4] && EVT_I.pll_locked)
        |=> !st_reg.alarm_status_flags_reg[4])
        else $error("pll flag clear failed");
    a_clk_clear: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && !SOFT_RST_I && wr_status && REG_WDATA_I[0] && !EVT_I.divider_mismatch)
        |=> !st_reg.alarm_status_flags_reg[0])
        else $error("clock flag clear failed");
    a_fifo_clear: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && !SOFT_RST_I && wr_status && REG_WDATA_I[5]
         && !(|(LANE_FIFO_ERR_I & LANE_ACTIVE_I))) |=> !st_reg.alarm_status_flags_reg[5])
        else $error("fifo flag clear failed");
    // Without a write the flag has no way back to zero
    a_status_sticky: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && !SOFT_RST_I && !wr_status && st_reg.alarm_status_flags_reg[2])
        |=> st_reg.alarm_status_flags_reg[2])
        else $error("realign flag dropped without a write");
    a_lane_sticky: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && !SOFT_RST_I && !wr_lane && !wr_status
         && st_reg.lane_fifo_alarm_flags_reg[7]) |=> st_reg.lane_fifo_alarm_flags_reg[7])
        else $error("lane flag dropped without a write");
    a_lane_clear: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && !SOFT_RST_I && wr_lane && REG_WDATA_I[0] && !LANE_FIFO_ERR_I[0])
        |=> !st_reg.lane_fifo_alarm_flags_reg[0])
        else $error("lane clear failed");
    a_lane_set_wins: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && wr_lane && REG_WDATA_I[7] && LANE_FIFO_ERR_I[7])
        |=> st_reg.lane_fifo_alarm_flags_reg[7])
        else $error("lane clear beat a persisting error");
    a_status_set_wins: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && wr_status && REG_WDATA_I[4] && !EVT_I.pll_locked)
        |=> st_reg.alarm_status_flags_reg[4])
        else $error("status clear beat a set condition");

    // ****************************************************************
    // Mask, aggregate and pin checks
    // ****************************************************************
    a_mask_write: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && !SOFT_RST_I && REG_WR_I && REG_ADDR_I == `LASM_OFS_MASK)
        |=> st_reg.alarm_mask_reg == $past(REG_WDATA_I))
        else $error("mask write lost");
    a_mask_silences: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (st_reg.alarm_mask_reg[5:0] == 6'h3F) |-> !ALARM_O)
        else $error("alarm raised with every flag masked");
    a_pin_alarm: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        CAL_STATUS_SEL_I |-> (CAL_STATUS_PIN_O == ALARM_O))
        else $error("alarm not routed to pin");
    a_pin_done: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        !CAL_STATUS_SEL_I |-> (CAL_STATUS_PIN_O == CAL_DONE_I))
        else $error("calibration done not routed to pin");

    // ****************************************************************
    // Read path and clock enable checks
    // ****************************************************************
    a_read_alarm: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && REG_RD_I && REG_ADDR_I == `LASM_OFS_ALARM)
        |=> REG_RDATA_O == {7'h00, $past(ALARM_O)})
        else $error("aggregate read wrong");
    a_read_status: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && REG_RD_I && REG_ADDR_I == `LASM_OFS_STATUS)
        |=> REG_RDATA_O == $past(st_reg.alarm_status_flags_reg))
        else $error("status read wrong");
    a_read_mask: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && REG_RD_I && REG_ADDR_I == `LASM_OFS_MASK)
        |=> REG_RDATA_O == $past(st_reg.alarm_mask_reg))
        else $error("mask read wrong");
    a_read_lane: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        (CLK_EN_I && REG_RD_I && REG_ADDR_I == `LASM_OFS_LANE)
        |=> REG_RDATA_O == $past(st_reg.lane_fifo_alarm_flags_reg))
        else $error("lane read wrong");
    a_read_hold: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        !(CLK_EN_I && REG_RD_I) |=> $stable(REG_RDATA_O))
        else $error("read data changed without a read");
    a_freeze: assert property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        !CLK_EN_I |=> $stable(st_reg))
        else $error("state moved while the clock enable was low");

    // ****************************************************************
    // Coverage
    // ****************************************************************
    c_link_startup: cover property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        ENC_MODE_I == lasm_pkg::LASM_ENC_64B66B && EVT_I.link_enable && !st_reg.link_en_d_reg);
    c_soft_reset: cover property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        CLK_EN_I && SOFT_RST_I);
    c_alarm_fires: cover property (@(posedge REF_CLK_I) disable iff (!NRST_I) $rose(ALARM_O));
    c_lane_clear: cover property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        wr_lane ##1 st_reg.lane_fifo_alarm_flags_reg == 8'h00);
    c_set_vs_clr: cover property (@(posedge REF_CLK_I) disable iff (!NRST_I)
        wr_status && REG_WDATA_I[4] && !EVT_I.pll_locked);
endmodule // lasm_alarm

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
`include "lasm_defs.svh"
module tb_top;
    localparam logic [11:0] A_AL = `LASM_OFS_ALARM;
    localparam logic [11:0] A_ST = `LASM_OFS_STATUS;
    localparam logic [11:0] A_MK = `LASM_OFS_MASK;
    localparam logic [11:0] A_LN = `LASM_OFS_LANE;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic clk_en = 1'b1;
    logic soft_rst = 1'b0;
    logic [11:0] addr = 12'h000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    lasm_pkg::lasm_enc_e enc = lasm_pkg::LASM_ENC_8B10B;
    lasm_pkg::lasm_evt_s evt = 6'h38;
    logic [7:0] lane_act = 8'h00;
    logic [7:0] lane_err = 8'h00;
    logic cal_sel = 1'b0;
    logic cal_done = 1'b0;
    logic alarm;
    logic cal_pin;
    int bad_count = 0;
    int comparisons = 0;
    int seed = 54853;
    logic [31:0] r;
    logic [7:0] m;
    logic [7:0] st;
    logic [5:0] ev_tab [6] = '{6'h18, 6'h30, 6'h3C, 6'h28, 6'h3A, 6'h39};
    int bit_tab [6] = '{4, 3, 3, 3, 2, 0};
    logic md_tab [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

    lasm_alarm i_lasm_alarm (.REF_CLK_I(clk), .NRST_I(nrst), .CLK_EN_I(clk_en),
        .SOFT_RST_I(soft_rst), .REG_ADDR_I(addr), .REG_WR_I(wr), .REG_RD_I(rd),
        .REG_WDATA_I(wdata), .REG_RDATA_O(rdata), .ENC_MODE_I(enc), .EVT_I(evt),
        .LANE_ACTIVE_I(lane_act), .LANE_FIFO_ERR_I(lane_err), .CAL_STATUS_SEL_I(cal_sel),
        .CAL_DONE_I(cal_done), .ALARM_O(alarm), .CAL_STATUS_PIN_O(cal_pin));

    initial begin
        forever #5 clk = ~clk;
    end
    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [7:0] exp_status(input logic [31:0] v);
        return {2'b00, |(v[15:8] & v[23:16]), v[0], 1'b0, v[1], 1'b0, v[2]};
    endfunction
    function automatic logic exp_alarm(input logic [7:0] s, input logic [7:0] k);
        return |(s & ~k & 8'h3D);
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
        cyc(1);
    endtask
    task automatic rd_chk(input string what, input logic [11:0] a, input logic [7:0] exp);
        addr = a;
        rd = 1'b1;
        cyc(1);
        rd = 1'b0;
        cyc(1);
        chk(what, rdata, exp);
    endtask
    // Holds one condition pattern for a cycle, then lets the flags settle
    task automatic pulse(input logic [5:0] e);
        evt = e;
        cyc(1);
        evt = 6'h38;
        cyc(3);
    endtask
    task automatic end_sim();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ************************************************************
    // Sequence
    // ************************************************************
    initial begin
        repeat (5) @(posedge clk);
        #1;
        nrst = 1'b1;
        rd_chk("mask_rst", A_MK, 8'h3F);
        rd_chk("lane_rst", A_LN, 8'hFF);
        rd_chk("status_rst", A_ST, 8'h3F);
        chk("alarm_rst", {7'h0, alarm}, 8'h00);
        wr_reg(A_ST, 8'h3F);
        rd_chk("status_clr", A_ST, 8'h00);
        rd_chk("lane_by_status", A_LN, 8'h00);
        for (int k = 0; k < 6; k++) begin
            enc = lasm_pkg::lasm_enc_e'({1'b0, md_tab[k]});
            cyc(3);
            wr_reg(A_ST, 8'h3F);
            pulse(ev_tab[k]);
            rd_chk("flag_set", A_ST, 8'h01 << bit_tab[k]);
            wr_reg(A_ST, 8'h01 << bit_tab[k]);
            rd_chk("flag_clr", A_ST, 8'h00);
        end
        lane_err = 8'h81;
        lane_act = 8'h01;
        cyc(2);
        // Error drops right after the clearing edge, so only set-beats-clear keeps the bits
        addr = A_LN;
        wdata = 8'hFF;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
        lane_err = 8'h00;
        cyc(1);
        rd_chk("lane_persist", A_LN, 8'h81);
        lane_err = 8'h00;
        wr_reg(A_LN, 8'h01);
        rd_chk("lane_one_clr", A_LN, 8'h80);
        rd_chk("fifo_flag", A_ST, 8'h20);
        wr_reg(A_ST, 8'h20);
        rd_chk("lane_all_clr", A_LN, 8'h00);
        evt = 6'h18;
        cyc(1);
        addr = A_ST;
        wdata = 8'h10;
        wr = 1'b1;
        cyc(1);
        wr = 1'b0;
        evt = 6'h38;
        cyc(1);
        rd_chk("set_wins", A_ST, 8'h10);
        evt = 6'h38;
        for (int k = 0; k < 24; k++) begin
            r = $random(seed);
            m = (k == 0) ? 8'h02 : ((r[31:24] & 8'h3D) | 8'h02);
            wr_reg(A_MK, m);
            rd_chk("mask_rw", A_MK, m);
            wr_reg(A_ST, 8'h3F);
            lane_err = r[15:8];
            lane_act = r[23:16];
            cal_sel = r[3];
            cal_done = r[4];
            pulse({~r[0], 2'b11, 1'b0, r[1], r[2]});
            lane_err = 8'h00;
            st = exp_status(r);
            rd_chk("status_mix", A_ST, st);
            rd_chk("lane_mix", A_LN, r[15:8]);
            chk("alarm_out", {7'h0, alarm}, {7'h0, exp_alarm(st, m)});
            rd_chk("alarm_reg", A_AL, {7'h0, exp_alarm(st, m)});
            chk("cal_pin", {7'h0, cal_pin}, {7'h0, r[3] ? exp_alarm(st, m) : r[4]});
        end
        clk_en = 1'b0;
        wr_reg(A_MK, 8'h3F);
        clk_en = 1'b1;
        rd_chk("frozen", A_MK, m);
        soft_rst = 1'b1;
        cyc(1);
        soft_rst = 1'b0;
        cyc(1);
        rd_chk("mask_soft", A_MK, 8'h3F);
        rd_chk("lane_soft", A_LN, 8'hFF);
        rd_chk("status_soft", A_ST, 8'h3F);
        rd_chk("unmapped", 12'h2C3, 8'h00);
        end_sim();
    end
    initial begin
        #100000;
        bad_count++;
        end_sim();
    end
endmodule // tb_top
